// [clock_receiver_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// receiver tallying high and low samples
// ********
module clock_receiver_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic [31:0] hi_q,
    output logic [31:0] lo_q,
    output logic [31:0] rise_q
);
    logic last_q;
    // sampled on the source clock, so totals are in source cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 32'h0;
            lo_q <= 32'h0;
            rise_q <= 32'h0;
            last_q <= 1'b0;
        end else begin
            last_q <= pin;
            hi_q <= hi_q + {31'h0, pin};
            lo_q <= lo_q + {31'h0, !pin};
            rise_q <= rise_q + {31'h0, pin && !last_q};
        end
    end
endmodule
`default_nettype wire

// [coarse_phase_map.vh]
// Functional notes
// - each output path has independent phase adjust
// - shift edges in whole source cycles
// - shortening clamps at two high, two low
// - one adjust spans 2^32 high plus low
// - positive lengthens, negative shortens, one period
// - symmetric duty splits adjust across both halves
// - programmed high time: adjust low part only
// - unlimited successive adjust requests accepted
// - each buffer differential or two single-ended
// - two-bit swing code 410 to 900 mV
// - three-bit common-mode code 0.9 to 2.3 V
// - single-ended emits two same clock copies
// - single-ended option inverts complement pin
// - single-ended five supplies, four impedances
// - 32-bit integer divider forms output clock
// - symmetric duty unless high count programmed
`ifndef COARSE_PHASE_MAP_VH
`define COARSE_PHASE_MAP_VH
// ****************************************************************
// register offsets inside one path window
// ****************************************************************
`define REG_DIV 3'h0
`define REG_HIGH 3'h1
`define REG_PHASE_LO 3'h2
`define REG_PHASE_HI 3'h3
`define REG_BUF 3'h4
`define REG_STATUS 3'h5
`define PATH_STRIDE_BIT 5
// ****************************************************************
// buffer config fields
// ****************************************************************
`define BUF_SINGLE_BIT 0
`define BUF_INVERT_BIT 1
`define BUF_SUPPLY_LSB 2
`define BUF_SUPPLY_MSB 4
`define BUF_SWING_LSB 5
`define BUF_SWING_MSB 6
`define BUF_CM_LSB 7
`define BUF_CM_MSB 9
`define BUF_IMP_LSB 10
`define BUF_IMP_MSB 11
`define BUF_ENABLE_BIT 12
`define BUF_WIDTH 13
// ****************************************************************
// reset values and limits
// ****************************************************************
`define DIV_RESET 32'h00000008
`define HIGH_RESET 32'h00000000
`define BUF_RESET 13'h0003
`define PHASE_LO_RESET 32'h00000000
`define PHASE_HI_RESET 2'h0
`define MIN_ADJ_PORTION 35'h000000002
`define MIN_PLAIN_PORTION 35'h000000001
`endif

// [coarse_phase_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// output stage checks
// ********
module coarse_phase_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic true_output_pin_0,
    input wire logic complement_output_pin_0,
    input wire logic single_ended_0,
    input wire logic output_enable_0,
    input wire logic [2:0] supply_range_code_0,
    input wire logic [1:0] swing_code_0,
    input wire logic [2:0] common_mode_code_0,
    input wire logic [1:0] impedance_code_0
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire t = true_output_pin_0;
    wire wb = psel && penable && pready && pwrite && paddr == 12'h010;
    logic [31:0] pw_q;
    always_ff @(posedge pclk) pw_q <= pwdata;
    AST_READY: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    AST_ERR: assert property (pready && (paddr[1:0] != 2'h0 ||
        paddr[11:6] != 6'h0 || paddr[4:3] == 2'h3) |-> pslverr)
        else $error("unmapped access without error");
    AST_BUF: assert property (wb |=>
        {output_enable_0, impedance_code_0, common_mode_code_0,
        swing_code_0, supply_range_code_0, single_ended_0}
        == {pw_q[12:2], pw_q[0]}) else $error("buffer fields stale");
    AST_DIFF: assert property (
        !single_ended_0 [*2] |-> complement_output_pin_0 != t)
        else $error("differential pair not complementary");
    AST_MIN_HIGH: assert property ($rose(t) |=> t)
        else $error("high portion below two cycles");
    AST_MIN_LOW: assert property (
        $fell(t) && output_enable_0 |=> !t)
        else $error("low portion below two cycles");
    AST_OFF: assert property (!output_enable_0 [*2] |-> !t)
        else $error("disabled path toggles");
    AST_START: assert property (
        $rose(output_enable_0) |-> ##[0:2] t)
        else $error("enabled path did not start a period");
    cover property ($rose(t));
    cover property (pready && pslverr);
    cover property ($fell(single_ended_0));
endmodule
bind coarse_phase_top coarse_phase_properties i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .true_output_pin_0(true_output_pin_0),
    .complement_output_pin_0(complement_output_pin_0),
    .single_ended_0(single_ended_0), .output_enable_0(output_enable_0),
    .supply_range_code_0(supply_range_code_0),
    .swing_code_0(swing_code_0), .common_mode_code_0(common_mode_code_0),
    .impedance_code_0(impedance_code_0)
);
`default_nettype wire

// [coarse_phase_top.v]
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "coarse_phase_map.vh"

// ****************************************************************
// one output path: divider, duty, coarse phase, pin drive
// ****************************************************************
module coarse_phase_path (
    input wire pclk,
    input wire presetn,
    input wire [31:0] div_ratio,
    input wire [31:0] high_count,
    input wire [33:0] adj_value,
    input wire adj_req,
    input wire single_ended,
    input wire invert_comp,
    input wire path_enable,
    output reg true_q,
    output reg comp_q,
    output reg pending_q,
    output reg clamped_q
);
    reg [34:0] cnt_q;
    reg [34:0] low_hold_q;
    reg [34:0] cnt_d;
    reg [34:0] low_hold_d;
    reg lvl_d;
    reg clamped_d;
    wire [31:0] base_high;
    wire [31:0] base_low;
    wire signed [34:0] adj_s;
    reg signed [34:0] adj_high;
    reg signed [34:0] adj_low;
    reg signed [34:0] want_high;
    reg signed [34:0] want_low;
    reg signed [34:0] min_part;
    reg signed [34:0] len_high;
    reg signed [34:0] len_low;
    reg clip_high;
    reg clip_low;
    wire at_boundary;
    wire take_adj;

    // one pclk cycle per source clock cycle
    assign base_high = (high_count != 32'h00000000) ? high_count :
                       {1'b0, div_ratio[31:1]};
    assign base_low = div_ratio - base_high;
    // sign extended 34-bit request covers 2^32 high plus 2^32 low
    assign adj_s = {adj_value[33], adj_value};
    assign at_boundary = !true_q && (cnt_q <= 35'h000000001);
    assign take_adj = at_boundary && pending_q && path_enable;

    // ************************************************************
    // adjust split between the two portions
    // ************************************************************
    // signed adj_s keeps the halving an arithmetic shift
    always @* begin
        adj_high = 35'sh000000000;
        adj_low = adj_s;
        // asymmetric pulse keeps its high time
        if (high_count == 32'h00000000) begin
            adj_high = adj_s >>> 1;
            adj_low = adj_s - adj_high;
        end
    end

    // ************************************************************
    // requested portions and the minimum-period floor
    // ************************************************************
    always @* begin
        want_high = $signed({3'b000, base_high});
        want_low = $signed({3'b000, base_low});
        min_part = $signed(`MIN_PLAIN_PORTION);
        if (take_adj) begin
            want_high = want_high + adj_high;
            want_low = want_low + adj_low;
            min_part = $signed(`MIN_ADJ_PORTION);
        end
        // clip truncates; nothing carried forward
        clip_high = want_high < min_part;
        clip_low = want_low < min_part;
        len_high = clip_high ? min_part : want_high;
        len_low = clip_low ? min_part : want_low;
    end

    // ************************************************************
    // period counter
    // ************************************************************
    always @* begin
        lvl_d = true_q;
        cnt_d = cnt_q;
        low_hold_d = low_hold_q;
        clamped_d = clamped_q;
        if (!path_enable) begin
            lvl_d = 1'b0;
            cnt_d = 35'h000000000;
        end else if (at_boundary) begin
            // period start loads both portions
            lvl_d = 1'b1;
            cnt_d = len_high;
            low_hold_d = len_low;
            if (take_adj) begin
                clamped_d = clip_high || clip_low;
            end
        end else if (true_q && cnt_q <= 35'h000000001) begin
            lvl_d = 1'b0;
            cnt_d = low_hold_q;
        end else begin
            cnt_d = cnt_q - 35'h000000001;
        end
    end

    // ************************************************************
    // pin registers and request flag
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            true_q <= 1'b0;
            comp_q <= 1'b1;
            cnt_q <= 35'h000000000;
            low_hold_q <= 35'h000000000;
            pending_q <= 1'b0;
            clamped_q <= 1'b0;
        end else begin
            true_q <= lvl_d;
            // single-ended: same clock on both pins unless inversion chosen; differential: complement
            if (single_ended) begin
                comp_q <= invert_comp ? ~lvl_d : lvl_d;
            end else begin
                comp_q <= ~lvl_d;
            end
            cnt_q <= cnt_d;
            low_hold_q <= low_hold_d;
            clamped_q <= clamped_d;
            // a new request beats the take in the same cycle
            if (adj_req) begin
                pending_q <= 1'b1;
            end else if (take_adj) begin
                pending_q <= 1'b0;
            end
        end
    end
endmodule

// ****************************************************************
// dual output stage with apb register file
// ****************************************************************
module coarse_phase_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output wire true_output_pin_0,
    output wire complement_output_pin_0,
    output wire true_output_pin_1,
    output wire complement_output_pin_1,
    output wire single_ended_0,
    output wire single_ended_1,
    output wire output_enable_0,
    output wire output_enable_1,
    output wire [2:0] supply_range_code_0,
    output wire [2:0] supply_range_code_1,
    output wire [1:0] swing_code_0,
    output wire [1:0] swing_code_1,
    output wire [2:0] common_mode_code_0,
    output wire [2:0] common_mode_code_1,
    output wire [1:0] impedance_code_0,
    output wire [1:0] impedance_code_1
);
    reg [31:0] div_q [0:1];
    reg [31:0] high_q [0:1];
    reg [31:0] phase_lo_q [0:1];
    reg [1:0] phase_hi_q [0:1];
    reg [`BUF_WIDTH-1:0] buf_q [0:1];
    reg [1:0] adj_req_q;
    reg [31:0] rdata_d;
    reg mapped_d;
    wire [1:0] pin_true;
    wire [1:0] pin_comp;
    wire [1:0] pending;
    wire [1:0] clamped;
    wire path_sel;
    wire [2:0] reg_sel;
    wire setup_phase;
    wire wr_take;
    integer i;

    assign path_sel = paddr[`PATH_STRIDE_BIT];
    assign reg_sel = paddr[4:2];
    assign setup_phase = psel && !penable;
    assign wr_take = psel && penable && pready && pwrite && !pslverr;

    // ************************************************************
    // read mux and address decode
    // ************************************************************
    always @* begin
        rdata_d = 32'h00000000;
        mapped_d = (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0) &&
                   (reg_sel <= `REG_STATUS);
        case (reg_sel)
            `REG_DIV: begin
                rdata_d = div_q[path_sel];
            end
            `REG_HIGH: begin
                rdata_d = high_q[path_sel];
            end
            `REG_PHASE_LO: begin
                rdata_d = phase_lo_q[path_sel];
            end
            `REG_PHASE_HI: begin
                rdata_d = {30'h00000000, phase_hi_q[path_sel]};
            end
            `REG_BUF: begin
                rdata_d = {19'h00000, buf_q[path_sel]};
            end
            `REG_STATUS: begin
                rdata_d = {29'h00000000, clamped[path_sel],
                           pin_true[path_sel], pending[path_sel]};
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
        if (!mapped_d) begin
            rdata_d = 32'h00000000;
        end
    end

    // answer one cycle after setup, never stalls longer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            if (setup_phase) begin
                prdata <= rdata_d;
                pslverr <= !mapped_d;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ************************************************************
    // register writes; each path has its own copy
    // ************************************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 2; i = i + 1) begin
                div_q[i] <= `DIV_RESET;
                high_q[i] <= `HIGH_RESET;
                phase_lo_q[i] <= `PHASE_LO_RESET;
                phase_hi_q[i] <= `PHASE_HI_RESET;
                buf_q[i] <= `BUF_RESET;
            end
            adj_req_q <= 2'b00;
        end else begin
            adj_req_q <= 2'b00;
            if (wr_take) begin
                case (reg_sel)
                    `REG_DIV: begin
                        div_q[path_sel] <= pwdata;
                    end
                    `REG_HIGH: begin
                        high_q[path_sel] <= pwdata;
                    end
                    `REG_PHASE_LO: begin
                        // low word write fires the request
                        phase_lo_q[path_sel] <= pwdata;
                        adj_req_q[path_sel] <= 1'b1;
                    end
                    `REG_PHASE_HI: begin
                        phase_hi_q[path_sel] <= pwdata[1:0];
                    end
                    `REG_BUF: begin
                        buf_q[path_sel] <= pwdata[`BUF_WIDTH-1:0];
                    end
                    `REG_STATUS: begin
                        // read-only; a write changes nothing
                        adj_req_q <= 2'b00;
                    end
                    default: begin
                        adj_req_q <= 2'b00;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // two independent paths
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : path
            coarse_phase_path u_path (
                .pclk(pclk),
                .presetn(presetn),
                .div_ratio(div_q[g]),
                .high_count(high_q[g]),
                .adj_value({phase_hi_q[g], phase_lo_q[g]}),
                .adj_req(adj_req_q[g]),
                .single_ended(buf_q[g][`BUF_SINGLE_BIT]),
                .invert_comp(buf_q[g][`BUF_INVERT_BIT]),
                .path_enable(buf_q[g][`BUF_ENABLE_BIT]),
                .true_q(pin_true[g]),
                .comp_q(pin_comp[g]),
                .pending_q(pending[g]),
                .clamped_q(clamped[g])
            );
        end
    endgenerate

    assign true_output_pin_0 = pin_true[0];
    assign complement_output_pin_0 = pin_comp[0];
    assign true_output_pin_1 = pin_true[1];
    assign complement_output_pin_1 = pin_comp[1];
    assign single_ended_0 = buf_q[0][`BUF_SINGLE_BIT];
    assign single_ended_1 = buf_q[1][`BUF_SINGLE_BIT];
    assign output_enable_0 = buf_q[0][`BUF_ENABLE_BIT];
    assign output_enable_1 = buf_q[1][`BUF_ENABLE_BIT];
    // supply code: five single-ended levels, three differential
    assign supply_range_code_0 = buf_q[0][`BUF_SUPPLY_MSB:`BUF_SUPPLY_LSB];
    assign supply_range_code_1 = buf_q[1][`BUF_SUPPLY_MSB:`BUF_SUPPLY_LSB];
    // swing 00 410mV, 01 600mV, 10 750mV, 11 900mV
    assign swing_code_0 = buf_q[0][`BUF_SWING_MSB:`BUF_SWING_LSB];
    assign swing_code_1 = buf_q[1][`BUF_SWING_MSB:`BUF_SWING_LSB];
    // crossing 0.9V plus 0.2V per code step
    assign common_mode_code_0 = buf_q[0][`BUF_CM_MSB:`BUF_CM_LSB];
    assign common_mode_code_1 = buf_q[1][`BUF_CM_MSB:`BUF_CM_LSB];
    assign impedance_code_0 = buf_q[0][`BUF_IMP_MSB:`BUF_IMP_LSB];
    assign impedance_code_1 = buf_q[1][`BUF_IMP_MSB:`BUF_IMP_LSB];
endmodule
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
// ********
// bench: apb driver, receivers, checks
// ********
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, rde;
    logic [11:0] paddr;
    logic [31:0] pwdata, rdv;
    wire [31:0] prdata;
    wire pready, pslverr;
    wire [1:0] tq, cq, se, oe;
    wire [3:0] sw, im;
    wire [5:0] su, cm;
    wire [63:0] ht, lt, rc;
    logic [12:0] b;
    int fails, n_checks, seed, dv[2], hg[2], d, h, a;
    int off[4] = '{0, 4, 8, 16};
    int rv[4] = '{8, 0, 0, 3};
    int cd[5] = '{8, 8, 9, 10, 6};
    int ch[5] = '{0, 0, 0, 3, 0};
    int ca[5] = '{2, -100, -3, 7, -1};
    coarse_phase_top i_coarse_phase_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .true_output_pin_0(tq[0]), .complement_output_pin_0(cq[0]),
        .true_output_pin_1(tq[1]), .complement_output_pin_1(cq[1]),
        .single_ended_0(se[0]), .single_ended_1(se[1]),
        .output_enable_0(oe[0]), .output_enable_1(oe[1]),
        .supply_range_code_0(su[2:0]), .supply_range_code_1(su[5:3]),
        .swing_code_0(sw[1:0]), .swing_code_1(sw[3:2]),
        .common_mode_code_0(cm[2:0]), .common_mode_code_1(cm[5:3]),
        .impedance_code_0(im[1:0]), .impedance_code_1(im[3:2]));
    clock_receiver_model i_rx0 (.pclk(pclk), .presetn(presetn),
        .pin(tq[0]), .hi_q(ht[31:0]), .lo_q(lt[31:0]), .rise_q(rc[31:0]));
    clock_receiver_model i_rx1 (.pclk(pclk), .presetn(presetn),
        .pin(tq[1]), .hi_q(ht[63:32]), .lo_q(lt[63:32]),
        .rise_q(rc[63:32]));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(logic w, int ad, logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= 12'(ad);
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic meas(int p, output int hs, output int ls);
        int r, h0, l0;
        @(posedge pclk);
        r = rc[p*32 +: 32];
        while (rc[p*32 +: 32] == r) @(posedge pclk);
        r = rc[p*32 +: 32];
        h0 = ht[p*32 +: 32];
        l0 = lt[p*32 +: 32];
        while (rc[p*32 +: 32] != r + 3) @(posedge pclk);
        hs = ht[p*32 +: 32] - h0;
        ls = lt[p*32 +: 32] - l0;
    endtask
    // three periods: {clamped, high total, low total}
    function automatic logic [64:0] sums(int dd, int hh, int aa);
        int hb, lb, ah, hn, ln;
        hb = (hh != 0) ? hh : dd / 2;
        lb = dd - hb;
        ah = (hh != 0) ? 0 : aa >>> 1;
        hn = (hb + ah < 2) ? 2 : hb + ah;
        ln = (lb + aa - ah < 2) ? 2 : lb + aa - ah;
        return {hn != hb + ah || ln != lb + aa - ah,
            32'(2 * hb + hn), 32'(2 * lb + ln)};
    endfunction
    task automatic adj(int p);
        logic [64:0] e, e2;
        logic [33:0] av;
        int hs, ls, h2, l2;
        av = 34'(a);
        e = sums(d, h, a);
        e2 = sums(dv[1-p], hg[1-p], 0);
        apb(1'b1, p * 32, d);
        apb(1'b1, p * 32 + 4, h);
        meas(p, hs, ls);
        apb(1'b1, p * 32 + 12, {30'h0, av[33:32]});
        apb(1'b1, p * 32 + 8, av[31:0]);
        fork
            meas(p, hs, ls);
            meas(1 - p, h2, l2);
        join
        chk("high total", e[63:32], hs);
        chk("low total", e[31:0], ls);
        chk("other path", e2[63:32], h2);
        apb(1'b0, p * 32 + 20, 0);
        chk("status", {29'h0, e[64], 2'h0}, rdv & 32'h5);
        dv[p] = d;
        hg[p] = h;
    endtask
    task automatic end_sim;
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        #(20 * 50000);
        fails++;
        end_sim();
    end
    initial begin
        seed = 32'h2fb8fcad;
        {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
        dv = '{8, 8};
        hg = '{0, 0};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk("reset pins", 32'h1, {30'h0, tq[0], cq[0]});
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, (i / 4) * 32 + off[i % 4], 0);
            chk("reset value", rv[i % 4], rdv);
        end
        foreach (rv[i]) begin
            apb(1'b0, 12'h018 + i * 12'h024 - (i / 3) * 12'h06a, 0);
            chk("error flag", 32'h1, {31'h0, rde});
            chk("error data", 32'h0, rdv);
        end
        for (int i = 0; i < 8; i++) begin
            b = {1'b1, i[1:0], i[2:0], i[1:0], 3'(i % 5), 2'b11};
            apb(1'b1, 16, b);
            apb(1'b0, 16, 0);
            chk("buffer", b, rdv);
            chk("pins", b, {oe[0], im[1:0], cm[2:0], sw[1:0], su[2:0],
                1'b1, se[0]});
            chk("inverted", {31'h0, ~tq[0]}, {31'h0, cq[0]});
        end
        apb(1'b1, 16, 13'h1001);
        apb(1'b1, 48, 13'h1003);
        chk("copy", {31'h0, tq[0]}, {31'h0, cq[0]});
        apb(1'b1, 16, 13'h1000);
        apb(1'b0, 20, 0);
        chk("pair", {31'h0, ~tq[0]}, {31'h0, cq[0]});
        chk("pins 1", 32'h1003, {oe[1], im[3:2], cm[5:3], sw[3:2], su[5:3],
            1'b1, se[1]});
        chk("inverted 1", {31'h0, ~tq[1]}, {31'h0, cq[1]});
        for (int k = 0; k < 11; k++) begin
            // ratios above four; random steps within 20 either way, fixed cases down to -100
            d = (k < 5) ? cd[k] : 5 + {$random(seed)} % 36;
            h = (k < 5) ? ch[k] : ($random(seed) & 1) ? 0
                : 2 + {$random(seed)} % (d - 3);
            a = (k < 5) ? ca[k] : {$random(seed)} % 41 - 20;
            adj(k % 2);
        end
        end_sim();
    end
endmodule
`default_nettype wire
